// ### hdl/tal_top.sv
// Threshold, hysteresis, fault-queue and shutdown logic of a temperature alarm block
//
// Local design decisions: the register addresses and the plain strobed port.
`include "tal_map.svh"

// What this block does
// - Config byte picks alert polarity and comparator or interrupt behaviour.
// - Alert pin is open drain: drives only while asserted, else released.
// - Interrupt behaviour alarms on readings above high or below low limit.
// - Interrupt alarm stays until any register read clears it.
// - After clearing, watch for the hysteresis crossing back and alarm again.
// - Interrupt alarm needs fault-queue-depth consecutive qualifying conversions.
// - Comparator alarm asserts after depth conversions above high or below low.
// - Comparator alarm drops after depth conversions back past hysteresis.
// - Comparator alarm clears by itself, no host action needed.
// - Overheat output is always comparator, asserting above the critical limit.
// - Overheat drops only below critical limit minus hysteresis.
// - Fault queue depth applies to both overheat assertion and release.
// - Shutdown bit set by host stops converter; bus keeps working.
// - In shutdown the temperature register keeps the last result.
// - Shutdown freezes both alarm outputs and holds fault counts at zero.
// - After shutdown the old temperature stays until a new conversion lands.
// - Bus address is a fixed prefix plus the address-select pin levels.
// - Config bit 1: zero comparator, one interrupt behaviour.
// - Config bits 2 and 3: overheat and alert polarity, one active high.
// - Config bit 0: zero normal conversions, one shutdown.
// - Fault queue depth is one after reset, four with queue enable set.
module tal_top #(
  parameter int NUM_ADDR_PINS = 4
) (
  input wire logic MCLK,
  input wire logic RST,
  input tal_pkg::tal_bus_req_t BUS,
  output logic [15:0] RD_DATA,
  input wire logic CONV_CLK,
  input wire logic [12:0] CONV_RESULT,
  input wire logic ADDR_SELECT_PIN_0,
  input wire logic ADDR_SELECT_PIN_1,
  input wire logic ADDR_SELECT_PIN_2,
  input wire logic ADDR_SELECT_PIN_3,
  output logic ALERT_OUT,
  output logic ALERT_OE,
  output logic OVERHEAT_OUT,
  output logic OVERHEAT_OE,
  output logic CONV_ENABLE,
  output logic [6:0] BUS_ADDRESS
);
  import tal_pkg::*;

  logic [15:0] temp_r;
  logic [7:0] cfg_r;
  logic [15:0] thyst_r;
  logic [15:0] tmax_r;
  logic [15:0] tlow_r;
  logic [15:0] thigh_r;
  logic [13:0] conv_s;
  logic [3:0] pins_s;
  logic conv_clk_prev_r;
  logic conv_evt;
  logic shdn;
  logic al_pol;
  logic ov_pol;
  logic intr_mode;
  logic [2:0] depth;
  logic signed [13:0] t_new;
  logic hi_fault;
  logic lo_fault;
  logic hi_back;
  logic lo_back;
  logic ov_fault;
  logic ov_back;
  logic al_qual;
  logic ov_qual;
  logic al_fire;
  logic ov_fire;
  tal_phase_t al_phase_r;
  tal_side_t al_side_r;
  tal_phase_t ov_phase_r;
  logic [2:0] al_cnt_r;
  logic [2:0] ov_cnt_r;
  logic al_irq_r;
  logic [15:0] rd_nxt;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Result bits must be steady a few clocks before the converter edge
  tal_sync #(.W(14)) u_sync_conv (
    .clk(MCLK),
    .rst(RST),
    .din({CONV_CLK, CONV_RESULT}),
    .dout(conv_s)
  );

  tal_sync #(.W(4)) u_sync_pins (
    .clk(MCLK),
    .rst(RST),
    .din({ADDR_SELECT_PIN_3, ADDR_SELECT_PIN_2, ADDR_SELECT_PIN_1, ADDR_SELECT_PIN_0}),
    .dout(pins_s)
  );

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      conv_clk_prev_r <= 1'b0;
    end else begin
      conv_clk_prev_r <= conv_s[13];
    end
  end

  // Converter halted in shutdown, so stray edges are dropped too
  assign conv_evt = conv_s[13] & ~conv_clk_prev_r & ~shdn;

  // ------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------
  assign shdn = cfg_r[`TAL_CFG_SHDN];
  assign intr_mode = cfg_r[`TAL_CFG_INTR];
  assign ov_pol = cfg_r[`TAL_CFG_OVPOL];
  assign al_pol = cfg_r[`TAL_CFG_ALPOL];
  assign depth = cfg_r[`TAL_CFG_FQEN] ? `TAL_FQ_FOUR : `TAL_FQ_ONE;

  // ------------------------------------------------------------
  // Threshold comparison in sixteenths of a degree
  // ------------------------------------------------------------
  function automatic logic signed [13:0] thr(input logic [15:0] r);
    return {r[15], r[15:`TAL_THR_LSB], `TAL_FRAC_PAD};
  endfunction

  assign t_new = {conv_s[12], conv_s[12:0]};
  assign hi_fault = t_new > thr(thigh_r);
  assign lo_fault = t_new < thr(tlow_r);
  assign hi_back = t_new < (thr(thigh_r) - thr(thyst_r));
  assign lo_back = t_new > (thr(tlow_r) + thr(thyst_r));
  assign ov_fault = t_new > thr(tmax_r);
  assign ov_back = t_new < (thr(tmax_r) - thr(thyst_r));

  // A return is judged against the side that raised the fault
  always_comb begin
    al_qual = 1'b0;
    ov_qual = 1'b0;
    case (al_phase_r)
      TAL_SEEK_FAULT: al_qual = hi_fault | lo_fault;
      TAL_SEEK_RETURN: al_qual = (al_side_r == TAL_SIDE_HIGH) ? hi_back : lo_back;
      default: al_qual = 1'b0;
    endcase
    case (ov_phase_r)
      TAL_SEEK_FAULT: ov_qual = ov_fault;
      TAL_SEEK_RETURN: ov_qual = ov_back;
      default: ov_qual = 1'b0;
    endcase
  end

  // At-or-above so a depth lowered mid-count still fires instead of wrapping
  assign al_fire = conv_evt & al_qual & ((al_cnt_r + `TAL_CNT_ONE) >= depth);
  assign ov_fire = conv_evt & ov_qual & ((ov_cnt_r + `TAL_CNT_ONE) >= depth);

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg_r <= `TAL_CFG_RST;
      thyst_r <= `TAL_THYST_RST;
      tmax_r <= `TAL_TMAX_RST;
      tlow_r <= `TAL_TLOW_RST;
      thigh_r <= `TAL_THIGH_RST;
    end else if (BUS.wr) begin
      case (BUS.addr)
        `TAL_OFS_CFG: cfg_r <= BUS.wdata[7:0] & `TAL_CFG_WMASK;
        `TAL_OFS_THYST: thyst_r <= BUS.wdata & `TAL_THR_MASK;
        `TAL_OFS_TMAX: tmax_r <= BUS.wdata & `TAL_THR_MASK;
        `TAL_OFS_TLOW: tlow_r <= BUS.wdata & `TAL_THR_MASK;
        `TAL_OFS_THIGH: thigh_r <= BUS.wdata & `TAL_THR_MASK;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Temperature result
  // ------------------------------------------------------------
  // Only a finished conversion replaces the held value
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      temp_r <= `TAL_TEMP_RST;
    end else if (conv_evt) begin
      temp_r <= {conv_s[12:0], `TAL_FLAG_PAD};
    end
  end

  // ------------------------------------------------------------
  // Alert fault queue and state
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      al_phase_r <= TAL_SEEK_FAULT;
      al_side_r <= TAL_SIDE_HIGH;
      al_cnt_r <= `TAL_CNT_ZERO;
    end else if (shdn) begin
      al_cnt_r <= `TAL_CNT_ZERO;
    end else if (conv_evt) begin
      if (!al_qual) begin
        al_cnt_r <= `TAL_CNT_ZERO;
      end else if (al_fire) begin
        al_cnt_r <= `TAL_CNT_ZERO;
        case (al_phase_r)
          TAL_SEEK_FAULT: begin
            al_phase_r <= TAL_SEEK_RETURN;
            al_side_r <= hi_fault ? TAL_SIDE_HIGH : TAL_SIDE_LOW;
          end
          TAL_SEEK_RETURN: al_phase_r <= TAL_SEEK_FAULT;
          default: al_phase_r <= TAL_SEEK_FAULT;
        endcase
      end else begin
        al_cnt_r <= al_cnt_r + `TAL_CNT_ONE;
      end
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      al_irq_r <= 1'b0;
    end else if (!intr_mode) begin
      al_irq_r <= 1'b0;
    end else if (al_fire) begin
      al_irq_r <= 1'b1;
    end else if (BUS.rd) begin
      al_irq_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Overheat fault queue and state
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ov_phase_r <= TAL_SEEK_FAULT;
      ov_cnt_r <= `TAL_CNT_ZERO;
    end else if (shdn) begin
      ov_cnt_r <= `TAL_CNT_ZERO;
    end else if (conv_evt) begin
      if (!ov_qual) begin
        ov_cnt_r <= `TAL_CNT_ZERO;
      end else if (ov_fire) begin
        ov_cnt_r <= `TAL_CNT_ZERO;
        ov_phase_r <= (ov_phase_r == TAL_SEEK_FAULT) ? TAL_SEEK_RETURN : TAL_SEEK_FAULT;
      end else begin
        ov_cnt_r <= ov_cnt_r + `TAL_CNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------
  // Open-drain pins, frozen through shutdown
  // ------------------------------------------------------------
  // Pull toward the active level only; a pull-up owns the idle level
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ALERT_OUT <= 1'b0;
      ALERT_OE <= 1'b0;
      OVERHEAT_OUT <= 1'b0;
      OVERHEAT_OE <= 1'b0;
    end else if (!shdn) begin
      ALERT_OUT <= al_pol;
      ALERT_OE <= intr_mode ? al_irq_r : (al_phase_r == TAL_SEEK_RETURN);
      OVERHEAT_OUT <= ov_pol;
      OVERHEAT_OE <= (ov_phase_r == TAL_SEEK_RETURN);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONV_ENABLE <= 1'b0;
      BUS_ADDRESS <= 7'h00;
    end else begin
      CONV_ENABLE <= ~shdn;
      BUS_ADDRESS <= (NUM_ADDR_PINS == 4) ? {`TAL_PFX_4PIN, pins_s} :
                     {`TAL_PFX_3PIN, pins_s[2:0]};
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_comb begin
    rd_nxt = 16'h0000;
    case (BUS.addr)
      `TAL_OFS_TEMP: rd_nxt = {temp_r[15:3], ov_phase_r == TAL_SEEK_RETURN,
                      (al_phase_r == TAL_SEEK_RETURN) && (al_side_r == TAL_SIDE_HIGH),
                      (al_phase_r == TAL_SEEK_RETURN) && (al_side_r == TAL_SIDE_LOW)};
      `TAL_OFS_CFG: rd_nxt = {8'h00, cfg_r};
      `TAL_OFS_THYST: rd_nxt = thyst_r;
      `TAL_OFS_TMAX: rd_nxt = tmax_r;
      `TAL_OFS_TLOW: rd_nxt = tlow_r;
      `TAL_OFS_THIGH: rd_nxt = thigh_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RD_DATA <= 16'h0000;
    end else begin
      RD_DATA <= BUS.rd ? rd_nxt : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  chk_read_clears_alert: assert property (
    (BUS.rd && intr_mode && !shdn && !al_fire) ##1 (intr_mode && !shdn && !al_fire)
    |=> !ALERT_OE)
    else $error("interrupt alert not cleared by read");

  chk_comp_alert_on: assert property (
    (!intr_mode && al_fire && al_phase_r == TAL_SEEK_FAULT) ##1 (!intr_mode && !shdn)
    |=> ALERT_OE)
    else $error("comparator alert did not assert");

  chk_comp_alert_off: assert property (
    (!intr_mode && al_fire && al_phase_r == TAL_SEEK_RETURN) ##1 (!intr_mode && !shdn)
    |=> !ALERT_OE)
    else $error("comparator alert did not release");

  chk_queue_depth_four: assert property (
    conv_evt && cfg_r[`TAL_CFG_FQEN] && al_cnt_r != 3'h3 |=> $stable(al_phase_r))
    else $error("alert moved before four conversions");

  chk_queue_depth_one: assert property (
    conv_evt && !cfg_r[`TAL_CFG_FQEN] |=> (al_phase_r != $past(al_phase_r)) == $past(al_qual)
    && (ov_phase_r != $past(ov_phase_r)) == $past(ov_qual))
    else $error("queue depth one not honoured");

  chk_outputs_frozen: assert property (
    shdn |=> $stable(ALERT_OE) && $stable(OVERHEAT_OE) && $stable(ALERT_OUT)
    && $stable(OVERHEAT_OUT))
    else $error("alarm pins moved in shutdown");

  chk_queue_held: assert property (
    shdn |=> al_cnt_r == 3'h0 && ov_cnt_r == 3'h0)
    else $error("fault count not held in shutdown");

  chk_temp_kept: assert property (
    shdn ##1 shdn |-> $stable(temp_r))
    else $error("temperature changed in shutdown");

  chk_overheat_on: assert property (
    (ov_fire && ov_phase_r == TAL_SEEK_FAULT) ##1 !shdn |=> OVERHEAT_OE)
    else $error("overheat did not assert");

  chk_drive_level: assert property (
    !shdn |=> ALERT_OUT == $past(al_pol))
    else $error("alert drives wrong level");

  chk_conv_stop: assert property (
    shdn |=> !CONV_ENABLE)
    else $error("converter left running in shutdown");

  cov_intr_fire: cover property (intr_mode && al_fire ##[1:40] BUS.rd);
  cov_comp_clear: cover property (!intr_mode && al_fire && al_phase_r == TAL_SEEK_RETURN);
  cov_overheat: cover property (ov_fire && ov_phase_r == TAL_SEEK_FAULT);
  cov_shutdown: cover property (!shdn ##1 shdn);
endmodule

// ### pkg/tal_map.svh
// Register offsets, field positions, reset values and fixed codes of the alarm block
`ifndef TAL_MAP_SVH
`define TAL_MAP_SVH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define TAL_OFS_TEMP 3'h0
`define TAL_OFS_CFG 3'h1
`define TAL_OFS_THYST 3'h2
`define TAL_OFS_TMAX 3'h3
`define TAL_OFS_TLOW 3'h4
`define TAL_OFS_THIGH 3'h5

// --------------------------------------------------------------
// Configuration byte fields
// --------------------------------------------------------------
`define TAL_CFG_SHDN 0
`define TAL_CFG_INTR 1
`define TAL_CFG_OVPOL 2
`define TAL_CFG_ALPOL 3
`define TAL_CFG_FQEN 4
`define TAL_CFG_WMASK 8'h3F

// --------------------------------------------------------------
// Reset values and field layout
// --------------------------------------------------------------
`define TAL_TEMP_RST 16'h0000
`define TAL_CFG_RST 8'h00
`define TAL_THYST_RST 16'h0100
`define TAL_TMAX_RST 16'h2800
`define TAL_TLOW_RST 16'h0500
`define TAL_THIGH_RST 16'h2000
`define TAL_THR_MASK 16'hFF80
`define TAL_THR_LSB 7
`define TAL_FRAC_PAD 4'h0
`define TAL_FLAG_PAD 3'h0

// --------------------------------------------------------------
// Fault queue depths and address prefixes
// --------------------------------------------------------------
`define TAL_FQ_ONE 3'h1
`define TAL_FQ_FOUR 3'h4
`define TAL_CNT_ZERO 3'h0
`define TAL_CNT_ONE 3'h1
`define TAL_PFX_4PIN 3'h4
`define TAL_PFX_3PIN 4'h9

`endif

// ### pkg/tal_pkg.sv
// Types shared by the temperature alarm block
package tal_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tal_bus_req_t;

  typedef enum logic {
    TAL_SEEK_FAULT = 1'b0,
    TAL_SEEK_RETURN = 1'b1
  } tal_phase_t;

  typedef enum logic {
    TAL_SIDE_LOW = 1'b0,
    TAL_SIDE_HIGH = 1'b1
  } tal_side_t;

endpackage

// ### hdl/tal_sync.sv
// Three-stage input synchroniser; a bit changes once stages two and three agree
module tal_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree;

  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Hold the old level while the two late stages disagree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= '0;
    end else begin
      dout <= (s3_r & agree) | (dout & ~agree);
    end
  end
endmodule

// ### tb/tal_host_model.sv
// Host-side model: register bus master and pulled-up open-drain alarm wires
module tal_host_model (
  input wire logic mclk,
  output tal_pkg::tal_bus_req_t bus,
  input wire logic [15:0] rd_data,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic overheat_out,
  input wire logic overheat_oe,
  output logic alert_wire,
  output logic overheat_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  import tal_pkg::*;

  // Pull-ups: a released wire reads high whatever the polarity
  assign alert_wire = alert_oe ? alert_out : 1'b1;
  assign overheat_wire = overheat_oe ? overheat_out : 1'b1;

  initial bus = '0;

  // Idle lines show the inverse so stale values cannot pass
  task automatic write_reg(input logic [2:0] addr, input logic [15:0] data);
    @(posedge mclk);
    bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask

  // Any read also clears a pending interrupt alarm
  task automatic read_reg(input logic [2:0] addr, output logic [15:0] data);
    @(posedge mclk);
    bus <= '{addr: addr, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '{addr: ~addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    @(negedge mclk);
    data = rd_data;
  endtask
endmodule

// ### tb/tal_top_tb.sv
// Self-checking bench of the temperature alarm block
module tal_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tal_pkg::*;

  logic mclk, rst, conv_clk, alert_out, alert_oe, overheat_out, overheat_oe, conv_enable;
  logic alert_wire, overheat_wire;
  logic [12:0] conv_result, last_t;
  logic [3:0] pins;
  logic [15:0] rd_data, d, thyst_v, tmax_v, tlow_v, thigh_v;
  logic [6:0] bus_address, bus_address3;
  logic [7:0] cfg_v;
  logic [31:0] seed, r;
  tal_bus_req_t bus;
  logic al_on, al_hi, ov_on, pend, pol_a, pol_o;
  int al_cnt, ov_cnt, mismatches, num_checks, lvl, prev;

  tal_top tal_top_i (.MCLK(mclk), .RST(rst), .BUS(bus), .RD_DATA(rd_data),
    .CONV_CLK(conv_clk), .CONV_RESULT(conv_result), .ADDR_SELECT_PIN_0(pins[0]),
    .ADDR_SELECT_PIN_1(pins[1]), .ADDR_SELECT_PIN_2(pins[2]), .ADDR_SELECT_PIN_3(pins[3]),
    .ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .OVERHEAT_OUT(overheat_out),
    .OVERHEAT_OE(overheat_oe), .CONV_ENABLE(conv_enable), .BUS_ADDRESS(bus_address));
  // Three-pin variant only for its address form
  tal_top #(.NUM_ADDR_PINS(3)) tal_top3_i (.MCLK(mclk), .RST(rst), .BUS(bus), .RD_DATA(),
    .CONV_CLK(conv_clk), .CONV_RESULT(conv_result), .ADDR_SELECT_PIN_0(pins[0]),
    .ADDR_SELECT_PIN_1(pins[1]), .ADDR_SELECT_PIN_2(pins[2]), .ADDR_SELECT_PIN_3(pins[3]),
    .ALERT_OUT(), .ALERT_OE(), .OVERHEAT_OUT(), .OVERHEAT_OE(), .CONV_ENABLE(),
    .BUS_ADDRESS(bus_address3));
  tal_host_model host_i (.mclk(mclk), .bus(bus), .rd_data(rd_data), .alert_out(alert_out),
    .alert_oe(alert_oe), .overheat_out(overheat_out), .overheat_oe(overheat_oe),
    .alert_wire(alert_wire), .overheat_wire(overheat_wire));

  always #20 mclk = ~mclk;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int thr(input logic [15:0] v);
    return $signed(v & 16'hFF80);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic set_reg(input logic [2:0] a, input logic [15:0] v);
    host_i.write_reg(a, v);
    case (a)
      3'h1: begin
        if (!v[1]) pend = 1'b0;
        if (v[0]) begin
          al_cnt = 0;
          ov_cnt = 0;
        end else begin
          pol_a = v[3];
          pol_o = v[2];
        end
        cfg_v = v[7:0] & 8'h3F;
      end
      3'h2: thyst_v = v;
      3'h3: tmax_v = v;
      3'h4: tlow_v = v;
      3'h5: thigh_v = v;
      default: ;
    endcase
  endtask

  // Reference state machine, one step per conversion
  task automatic ref_update(input int t16);
    int tv, hi, lo, hy, depth;
    logic hit;
    tv = t16 * 8;
    hi = thr(thigh_v);
    lo = thr(tlow_v);
    hy = thr(thyst_v);
    depth = cfg_v[4] ? 4 : 1;
    last_t = t16[12:0];
    hit = !al_on ? (tv > hi || tv < lo) : (al_hi ? tv < hi - hy : tv > lo + hy);
    al_cnt = hit ? al_cnt + 1 : 0;
    if (al_cnt >= depth) begin
      if (!al_on) al_hi = tv > hi;
      al_on = !al_on;
      al_cnt = 0;
      if (cfg_v[1]) pend = 1'b1;
    end
    hit = ov_on ? tv < thr(tmax_v) - hy : tv > thr(tmax_v);
    ov_cnt = hit ? ov_cnt + 1 : 0;
    if (ov_cnt >= depth) begin
      ov_on = !ov_on;
      ov_cnt = 0;
    end
  endtask

  task automatic read_temp();
    host_i.read_reg(3'h0, d);
    pend = 1'b0;
    check(d, {last_t, ov_on, al_on & al_hi, al_on & !al_hi});
  endtask

  // One conversion frame; the link clock idles low between frames
  task automatic convert(input int t16);
    logic eoe;
    @(posedge mclk);
    conv_result <= t16[12:0];
    repeat (4) @(posedge mclk);
    conv_clk <= 1'b1;
    repeat (4) @(posedge mclk);
    conv_clk <= 1'b0;
    repeat (4) @(posedge mclk);
    conv_result <= ~t16[12:0];
    if (!cfg_v[0]) ref_update(t16);
    @(negedge mclk);
    eoe = cfg_v[1] ? pend : al_on;
    check(alert_oe, eoe);
    check(overheat_oe, ov_on);
    check({alert_out, overheat_out}, {pol_a, pol_o});
    check({alert_wire, overheat_wire}, {eoe ? pol_a : 1'b1, ov_on ? pol_o : 1'b1});
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    mclk = 0;
    rst = 1;
    conv_clk = 0;
    conv_result = '0;
    pins = '0;
    seed = 18446;
    {al_on, al_hi, ov_on, pend, pol_a, pol_o} = '0;
    {al_cnt, ov_cnt, mismatches, num_checks, prev} = '0;
    {thyst_v, tmax_v, tlow_v, thigh_v} = {16'h0100, 16'h2800, 16'h0500, 16'h2000};
    cfg_v = 8'h00;
    last_t = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(conv_enable, 1'b1);
    read_temp();
    foreach (thyst_v[i]) if (i < 7) begin
      host_i.read_reg(i[2:0], d);
      check(d, i == 1 ? 16'h0000 : i == 2 ? thyst_v : i == 3 ? tmax_v : i == 4 ? tlow_v
        : i == 5 ? thigh_v : 16'h0000);
    end
    @(negedge mclk);
    check(rd_data, 16'h0000);
    for (int a = 0; a < 16; a++) begin
      @(posedge mclk);
      pins <= a[3:0];
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      check(bus_address, {3'b100, a[3:0]});
      check(bus_address3, {4'b1001, a[2:0]});
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      set_reg(i[2:0], r[15:0]);
      host_i.read_reg(i[2:0], d);
      check(d, i == 1 ? {8'h00, cfg_v} : (i > 1 && i < 6) ? r[15:0] & 16'hFF80 : 16'h0000);
    end
    set_reg(3'h2, 16'h0100);
    set_reg(3'h3, 16'h1900);
    set_reg(3'h4, 16'h0500);
    set_reg(3'h5, 16'h0F00);
    for (int s = 0; s < 4; s++) begin
      repeat (4) convert(320);
      r = rnd();
      set_reg(3'h1, {10'h000, r[5], s[0], r[3:2], s[1], 1'b0});
      read_temp();
      for (int b = 0; b < 30; b++) begin
        r = rnd();
        lvl = int'(r[5:0] % 60) - 5;
        if ((lvl > 20) != (prev > 20)) convert(320);
        prev = lvl;
        repeat (1 + r[8:6] % 5) convert(lvl * 16 + r[13:10]);
        if (r[14]) read_temp();
      end
    end
    repeat (4) convert(880);
    repeat (3) convert(320);
    read_temp();
    set_reg(3'h1, {8'h00, cfg_v ^ 8'h0D});
    // Enable output is registered one edge behind the config bit
    repeat (2) @(negedge mclk);
    check(conv_enable, 1'b0);
    repeat (2) convert(160);
    read_temp();
    set_reg(3'h1, {8'h00, cfg_v & 8'hFE});
    repeat (2) @(negedge mclk);
    check(conv_enable, 1'b1);
    read_temp();
    convert(320);
    read_temp();
    repeat (3) convert(320);
    read_temp();
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  end
endmodule
